// ===== design/gppio_pkg.sv
package gppio_pkg;
    // -----------------------------------------------------------------
    // Register addresses
    // -----------------------------------------------------------------
    localparam logic [7:0] GPPIO_ADDR_PORT0_DATA = 8'h80;
    localparam logic [7:0] GPPIO_ADDR_PORT1_DATA = 8'h90;
    localparam logic [7:0] GPPIO_ADDR_PORT0_CFG = 8'hA4;
    localparam logic [7:0] GPPIO_ADDR_PORT1_CFG = 8'hA5;
    localparam logic [7:0] GPPIO_ADDR_ROUTE = 8'hE3;
    localparam logic [7:0] GPPIO_ADDR_PORT0_MODE = 8'hF1;
    localparam logic [7:0] GPPIO_ADDR_PORT1_MODE = 8'hF2;
    // -----------------------------------------------------------------
    // Reset values
    // -----------------------------------------------------------------
    localparam logic [7:0] GPPIO_RST_DATA = 8'hFF;
    localparam logic [7:0] GPPIO_RST_CFG = 8'h00;
    localparam logic [7:0] GPPIO_RST_ROUTE = 8'h00;
    localparam logic [7:0] GPPIO_RST_MODE = 8'hFF;
    // -----------------------------------------------------------------
    // Routing register fields
    // -----------------------------------------------------------------
    localparam int GPPIO_BIT_GLOBAL_PUD = 7;
    localparam int GPPIO_BIT_PORT3_PUD = 6;
    localparam int GPPIO_BIT_PORT2_PUD = 5;
    localparam int GPPIO_BIT_PORT1_PUD = 4;
    localparam int GPPIO_BIT_PORT0_PUD = 3;
    localparam int GPPIO_BIT_SPI_EN = 0;
    localparam logic [7:0] GPPIO_ROUTE_WMASK = 8'hF9;
    localparam int GPPIO_NPORT = 2;
endpackage : gppio_pkg

// ===== design/gppio_top.sv
// Behaviour
// [RULE1] Each port data register is reachable as a whole byte and as single addressed bits.
// [RULE2] A write to a port data register is held in its latch and driven onto the pins.
// [RULE3] A plain read returns pin levels, gated to zero where the pin is in analog mode.
// [RULE4] Read-modify-write byte accesses read the latch instead of the pins.
// [RULE5] Bit move, clear and set to a port bit read and rewrite the latch value.
// [RULE6] A cleared config bit gives open-drain, a set bit push-pull; reset gives open-drain.
module gppio_top
    import gppio_pkg::*;
(
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // Byte access port
    input wire logic [7:0] i_addr,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic i_rmw,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata,
    // Bit access port
    input wire logic [7:0] i_bit_addr,
    input wire logic i_bit_wr,
    input wire logic i_bit_rd,
    input wire logic i_bit_rmw,
    input wire logic i_bit_wdata,
    output logic o_bit_rdata,
    // Pins
    input wire logic [15:0] i_pin,
    output logic [15:0] o_pin,
    output logic [15:0] o_pin_oe_n,
    // Pull-up and routing controls
    output logic [3:0] o_port_pullup_disable,
    output logic o_serial_periph_route_enable
);
    // -----------------------------------------------------------------
    // Registers
    // -----------------------------------------------------------------
    logic [7:0] data_reg [GPPIO_NPORT];
    logic [7:0] cfg_reg [GPPIO_NPORT];
    logic [7:0] mode_reg [GPPIO_NPORT];
    logic [7:0] route_reg;
    logic [7:0] rdata_reg;
    logic bit_rdata_reg;

    // -----------------------------------------------------------------
    // Bit address decode: byte base is the upper five bits times eight
    // -----------------------------------------------------------------
    wire [7:0] bit_byte_addr = {i_bit_addr[7:3], 3'b000};
    wire [2:0] bit_idx = i_bit_addr[2:0];
    wire route_wr = i_wr && (i_addr == GPPIO_ADDR_ROUTE);
    logic [7:0] byte_rd [GPPIO_NPORT];
    logic [7:0] bit_rd [GPPIO_NPORT];

    // -----------------------------------------------------------------
    // Per-port logic
    // -----------------------------------------------------------------
    genvar p;
    genvar b;
    generate
        for (p = 0; p < GPPIO_NPORT; p++) begin : g_port
            // Per-port register addresses
            localparam logic [7:0] DADDR =
                (p == 0) ? GPPIO_ADDR_PORT0_DATA : GPPIO_ADDR_PORT1_DATA;
            localparam logic [7:0] CADDR =
                (p == 0) ? GPPIO_ADDR_PORT0_CFG : GPPIO_ADDR_PORT1_CFG;
            localparam logic [7:0] MADDR =
                (p == 0) ? GPPIO_ADDR_PORT0_MODE : GPPIO_ADDR_PORT1_MODE;

            // Write decode
            wire data_wr = i_wr && (i_addr == DADDR); // [RULE1]
            wire bit_hit = i_bit_wr && (bit_byte_addr == DADDR); // [RULE1]
            wire cfg_wr = i_wr && (i_addr == CADDR);
            wire mode_wr = i_wr && (i_addr == MADDR);

            // Read sources
            wire [7:0] pins = i_pin[p*8 +: 8] & mode_reg[p]; // [RULE3]
            wire [7:0] bit_mask = 8'h01 << bit_idx;

            // Bit write merges into latch, so other bits keep latch value
            wire [7:0] bit_merge = (data_reg[p] & ~bit_mask)
                | ({8{i_bit_wdata}} & bit_mask); // [RULE5]

            // Byte write beats a same-cycle bit write
            wire [7:0] data_next = data_wr ? i_wdata : bit_merge; // [RULE2]
            wire data_load = data_wr || bit_hit;

            // Latch source for rmw, pins otherwise
            assign byte_rd[p] = i_rmw ? data_reg[p] : pins; // [RULE3] [RULE4]
            assign bit_rd[p] = i_bit_rmw ? data_reg[p] : pins; // [RULE5]

            // Output latch
            always_ff @(posedge i_sys_clk) begin
                if (i_rst) begin
                    data_reg[p] <= GPPIO_RST_DATA;
                end else if (data_load) begin
                    data_reg[p] <= data_next; // [RULE2]
                end
            end

            // Output configuration
            always_ff @(posedge i_sys_clk) begin
                if (i_rst) begin
                    cfg_reg[p] <= GPPIO_RST_CFG; // [RULE6]
                end else if (cfg_wr) begin
                    cfg_reg[p] <= i_wdata; // [RULE6]
                end
            end

            // Input mode
            always_ff @(posedge i_sys_clk) begin
                if (i_rst) begin
                    mode_reg[p] <= GPPIO_RST_MODE;
                end else if (mode_wr) begin
                    mode_reg[p] <= i_wdata; // [RULE3]
                end
            end

            // Per-pin drive
            for (b = 0; b < 8; b++) begin : g_pin
                wire push_pull = cfg_reg[p][b];
                wire latch_bit = data_reg[p][b];
                // Open-drain: a latched one releases the pin
                assign o_pin[p*8 + b] = latch_bit; // [RULE2]
                assign o_pin_oe_n[p*8 + b] = ~push_pull & latch_bit; // [RULE6]
            end
        end
    endgenerate

    // -----------------------------------------------------------------
    // Read address decode
    // -----------------------------------------------------------------
    wire hit_port0_data = (i_addr == GPPIO_ADDR_PORT0_DATA);
    wire hit_port1_data = (i_addr == GPPIO_ADDR_PORT1_DATA);
    wire hit_port0_cfg = (i_addr == GPPIO_ADDR_PORT0_CFG);
    wire hit_port1_cfg = (i_addr == GPPIO_ADDR_PORT1_CFG);
    wire hit_route = (i_addr == GPPIO_ADDR_ROUTE);
    wire hit_port0_mode = (i_addr == GPPIO_ADDR_PORT0_MODE);
    wire hit_port1_mode = (i_addr == GPPIO_ADDR_PORT1_MODE);

    // -----------------------------------------------------------------
    // Bit read decode
    // -----------------------------------------------------------------
    wire bit_hit_port0 = (bit_byte_addr == GPPIO_ADDR_PORT0_DATA); // [RULE1]
    wire bit_hit_port1 = (bit_byte_addr == GPPIO_ADDR_PORT1_DATA); // [RULE1]

    // -----------------------------------------------------------------
    // Read mux
    // -----------------------------------------------------------------
    // Unmapped addresses read zero
    wire [7:0] rd_mux = ({8{hit_port0_data}} & byte_rd[0])
        | ({8{hit_port1_data}} & byte_rd[1])
        | ({8{hit_port0_cfg}} & cfg_reg[0])
        | ({8{hit_port1_cfg}} & cfg_reg[1])
        | ({8{hit_route}} & route_reg)
        | ({8{hit_port0_mode}} & mode_reg[0])
        | ({8{hit_port1_mode}} & mode_reg[1]);

    // Bits outside the port bytes read zero
    wire bit_mux = (bit_hit_port0 & bit_rd[0][bit_idx])
        | (bit_hit_port1 & bit_rd[1][bit_idx]);

    // -----------------------------------------------------------------
    // Pull-up and routing register
    // -----------------------------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            route_reg <= GPPIO_RST_ROUTE;
        end else if (route_wr) begin
            route_reg <= i_wdata & GPPIO_ROUTE_WMASK;
        end
    end

    // -----------------------------------------------------------------
    // Byte read data
    // -----------------------------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            rdata_reg <= 8'h00;
        end else if (i_rd) begin
            rdata_reg <= rd_mux; // [RULE3] [RULE4]
        end
    end

    // -----------------------------------------------------------------
    // Bit read data
    // -----------------------------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            bit_rdata_reg <= 1'b0;
        end else if (i_bit_rd) begin
            bit_rdata_reg <= bit_mux; // [RULE5]
        end
    end

    // -----------------------------------------------------------------
    // Outputs
    // -----------------------------------------------------------------
    assign o_rdata = rdata_reg;
    assign o_bit_rdata = bit_rdata_reg;
    assign o_serial_periph_route_enable = route_reg[GPPIO_BIT_SPI_EN];

    // -----------------------------------------------------------------
    // Pull-up disables
    // -----------------------------------------------------------------
    genvar q;
    generate
        for (q = 0; q < 4; q++) begin : g_pullup
            // Global disable overrides each port disable
            assign o_port_pullup_disable[q] = route_reg[GPPIO_BIT_GLOBAL_PUD]
                | route_reg[GPPIO_BIT_PORT0_PUD + q];
        end
    endgenerate
endmodule : gppio_top

// ===== sim/gppio_properties.sv
module gppio_properties (
    input wire logic i_sys_clk, i_rst, i_wr, i_rd, i_rmw, i_bit_wr, i_bit_rd, i_bit_rmw,
    input wire logic i_bit_wdata, o_bit_rdata,
    input wire logic [7:0] i_addr, i_wdata, i_bit_addr, o_rdata,
    input wire logic [15:0] i_pin, o_pin, o_pin_oe_n
);
    // ----
    // Checks
    // ----
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    wire logic port0_bit = i_bit_addr[7:3] == 5'h10;
    wire logic lat_bit = o_pin[i_bit_addr[2:0]];
    byte_latch_a: assert property (i_wr && i_addr == 8'h80 |=> o_pin[7:0] == $past(i_wdata))
        else $error("byte write not latched");
    pin_hold_a: assert property (!i_wr && !i_bit_wr |=> $stable(o_pin))
        else $error("pins moved without write");
    bit_latch_a: assert property (i_bit_wr && !i_wr && port0_bit |=>
        o_pin[$past(i_bit_addr[2:0])] == $past(i_bit_wdata)) else $error("bit write lost");
    rmw_byte_a: assert property (i_rd && i_rmw && i_addr == 8'h90 |=>
        o_rdata == $past(o_pin[15:8])) else $error("rmw read not latch");
    rmw_bit_a: assert property (i_bit_rd && i_bit_rmw && port0_bit |=>
        o_bit_rdata == $past(lat_bit)) else $error("bit rmw read not latch");
    plain_rd_a: assert property (i_rd && !i_rmw && i_addr == 8'h80 |=>
        (o_rdata & ~$past(i_pin[7:0])) == 8'h00) else $error("plain read not pins");
    drain_a: assert property ((~o_pin & o_pin_oe_n) == 16'h0000)
        else $error("low latch not driven");
    rdata_hold_a: assert property (!i_rd |=> $stable(o_rdata)) else $error("read data moved");
endmodule : gppio_properties

// ===== sim/gppio_board.sv
module gppio_board (
    input wire logic [15:0] o_pin, o_pin_oe_n, ext_val, ext_en,
    output logic [15:0] pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // Released pins pulled up unless driven from outside
    assign pin = (~o_pin_oe_n & o_pin) | (o_pin_oe_n & (~ext_en | ext_val));
endmodule : gppio_board

// ===== sim/gppio_top_tb.sv
module gppio_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_sys_clk = 0, i_rst = 1, i_wr = 0, i_rd = 0, i_rmw = 0, i_bit_wr = 0, i_bit_rd = 0;
    logic i_bit_rmw = 0, i_bit_wdata = 0, o_bit_rdata, bv;
    logic [7:0] i_addr = 0, i_wdata = 0, i_bit_addr = 0, o_rdata, a, c, b, m;
    logic [15:0] i_pin, o_pin, o_pin_oe_n, ext_val = 0, ext_en = 0, lat = 16'hFFFF, cfg = 0;
    logic [15:0] mode = 16'hFFFF, ex;
    logic [3:0] o_port_pullup_disable;
    logic o_serial_periph_route_enable;
    int n_errors = 0, n_compared = 0, cyc = 0, base;
    always #5 i_sys_clk = ~i_sys_clk;
    gppio_top gppio_top_i (.*);
    gppio_board gppio_board_i (.o_pin, .o_pin_oe_n, .ext_val, .ext_en, .pin(i_pin));
    // ----
    // Tasks
    // ----
    function automatic logic [15:0] pins();
        return lat & (cfg | ~ext_en | ext_val);
    endfunction : pins
    task automatic chk(input logic [15:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic op(input logic w, r, m, input logic [7:0] ad, d);
        @(posedge i_sys_clk);
        {i_wr, i_rd, i_rmw, i_addr, i_wdata} <= {w, r, m, ad, d};
        @(posedge i_sys_clk);
        {i_wr, i_rd} <= 2'b00;
        #1;
    endtask : op
    task automatic bop(input logic w, r, m, input logic [7:0] ad, input logic d);
        @(posedge i_sys_clk);
        {i_bit_wr, i_bit_rd, i_bit_rmw, i_bit_addr, i_bit_wdata} <= {w, r, m, ad, d};
        @(posedge i_sys_clk);
        {i_bit_wr, i_bit_rd} <= 2'b00;
        #1;
    endtask : bop
    task automatic print_verdict();
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : print_verdict
    always @(posedge i_sys_clk) begin
        if (++cyc == 5000) begin
            n_errors++;
            print_verdict();
        end
    end
    // ----
    // Sequence
    // ----
    initial begin
        void'($urandom(32'h8006));
        repeat (2) @(posedge i_sys_clk);
        i_rst <= 0;
        op(0, 1, 0, 8'hA4, 0);
        chk(o_rdata, 0);
        chk(o_pin_oe_n, 16'hFFFF);
        repeat (40) begin
            a = $urandom_range(1, 0) ? 8'h90 : 8'h80;
            base = a[4] ? 8 : 0;
            {ext_en, ext_val} = $urandom;
            {c, b, bv} = $urandom;
            m = $urandom;
            op(1, 0, 0, a, b);
            lat[base+:8] = b;
            op(1, 0, 0, 8'hA4 + a[4], c);
            cfg[base+:8] = c;
            op(1, 0, 0, 8'hF1 + a[4], m);
            mode[base+:8] = m;
            b = {a[7:3], 3'($urandom)};
            bop(1, 0, 0, b, bv);
            lat[base + b[2:0]] = bv;
            chk(o_pin, lat);
            chk(o_pin_oe_n, ~cfg & lat);
            op(0, 1, 1, a, 0);
            chk(o_rdata, lat[base+:8]);
            op(0, 1, 0, a, 0);
            ex = pins() & mode;
            chk(o_rdata, ex >> base & 16'h00FF);
            bop(0, 1, 0, b, 0);
            chk(o_bit_rdata, ex[base + b[2:0]]);
            bop(0, 1, 1, b, 0);
            chk(o_bit_rdata, lat[base + b[2:0]]);
        end
        repeat (8) begin
            c = $urandom;
            op(1, 0, 0, 8'hE3, c);
            chk(o_port_pullup_disable, {4{c[7]}} | c[6:3]);
            chk(o_serial_periph_route_enable, c[0]);
            op(0, 1, 0, 8'hE3, 0);
            chk(o_rdata, c & 8'hF9);
        end
        op(0, 1, 0, 8'h81, 0);
        chk(o_rdata, 0);
        print_verdict();
    end
endmodule : gppio_top_tb
bind gppio_top gppio_properties gppio_properties_i (.*);
